//--- design/mcs_autosetup.sv
// How it works
// - 2031 current: stepper rated, BLDC peak
// - BLDC rated current and peak duration used
// - 08h selects stepper with standstill reduction
// - 41h selects BLDC motor type
// - encoder cfg 0 differential, 2 single-ended
// - 0Ch/44h add brake control
// - closed loop only after successful setup
// - controlword bit 4 starts the measurement runs
// - statusword bit 12 set when setup succeeds
// - statusword bit 10 reports index found
// - encoder and hall phases only when fitted
// - results load as each run ends, success stores drive and tuning
// - limit switches stay active during setup
// - bus answers may lag during setup
// - mode 2 runs at target velocity
// - controlword 6 stops the motor
`timescale 1ns/1ps
`default_nettype none
module mcs_autosetup #(
  parameter int MS_CYCLES = mcs_pkg::MS_CYCLES_DEF
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [mcs_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [mcs_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic index_pin,
  input wire logic [2:0] hall_pin,
  input wire logic limit_pos_pin,
  input wire logic limit_neg_pin,
  input wire logic prog_run_pin,
  input wire logic [15:0] meas_value,
  output mcs_pkg::mcs_drive_cfg_t drive_cfg,
  output logic motor_en,
  output logic setup_busy,
  output logic [31:0] velocity_cmd,
  output logic store_drive,
  output logic store_tuning
);
  import mcs_pkg::*;
  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic aw_got;
    logic w_got;
    logic ar_got;
    logic [ADDR_W-1:0] awaddr;
    logic [ADDR_W-1:0] araddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [2:0] lat;
    logic awready;
    logic wready;
    logic arready;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [31:0] pole_pairs;
    logic [31:0] max_cur;
    logic [31:0] rated_cur;
    logic [31:0] peak_ms;
    logic [31:0] submode;
    logic [31:0] enc_cfg;
    logic [31:0] mode;
    logic [31:0] cw;
    logic [31:0] tvel;
    logic [31:0] setup_cfg;
    mcs_phase_t phase;
    logic [RES_N-1:0][15:0] res;
    logic [15:0] hall_cnt;
    logic idx_found;
    logic done;
    logic setup_ok;
    logic setup_fail;
    logic coord_valid;
    logic cw4_prev;
    logic idx_prev;
    logic [2:0] hall_prev;
    logic tstart;
    mcs_drive_cfg_t cfg;
    logic motor_en;
    logic [31:0] vel;
    logic st_drive;
    logic st_tune;
    logic busy_o;
  } mcs_state_t;
  mcs_state_t s_q, s_d;
  logic idx_lvl, lim_pos, lim_neg, prog_run, tmr_done;
  logic [2:0] hall_lvl;
  logic op_en, busy, limit_hit, commit_ok, wr_go, rd_go;
  logic [31:0] rd_word;
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction
  function automatic logic is_result(input logic [ADDR_W-1:0] a);
    return (a[7:5] == REG_RESULT_BASE[7:5]) && (a[4:2] < 3'(RES_N)) && (a[1:0] == 2'h0);
  endfunction
  function automatic mcs_phase_t next_phase(input mcs_phase_t p, input logic [31:0] c);
    mcs_phase_t n;
    n = PH_STORE;
    unique case (p)
      PH_IDLE: n = PH_TYPE;
      PH_TYPE: n = PH_RES;
      PH_RES: n = PH_IND;
      PH_IND: n = PH_FLUX;
      PH_FLUX: n = c[CFG_INDEX_BIT] ? PH_ENC : (c[CFG_HALL_BIT] ? PH_HALL : PH_STORE);
      PH_ENC: n = PH_ALIGN;
      PH_ALIGN: n = c[CFG_HALL_BIT] ? PH_HALL : PH_STORE;
      PH_HALL: n = PH_STORE;
      PH_STORE: n = PH_IDLE;
    endcase
    return n;
  endfunction
  // ****************************************
  // pins and phase timer
  // ****************************************
  mcs_pin_sync #(.W(7)) u_sync (
    .clk(aclk),
    .rst_n(aresetn),
    .pin({index_pin, hall_pin, limit_pos_pin, limit_neg_pin, prog_run_pin}),
    .level({idx_lvl, hall_lvl, lim_pos, lim_neg, prog_run})
  );
  mcs_ms_timer #(.MS_CYCLES(MS_CYCLES)) u_tmr (
    .clk(aclk),
    .rst_n(aresetn),
    .start(s_q.tstart),
    .len_ms(PHASE_MS),
    .done(tmr_done)
  );
  assign op_en = (s_q.cw[3:0] == CW_OP_ENABLE);
  assign busy = (s_q.phase != PH_IDLE);
  assign limit_hit = lim_pos || lim_neg;
  // fieldbus answers wait while the measurement runs hog the core
  assign commit_ok = !busy || (s_q.lat == BUSY_LAT);
  assign wr_go = s_q.aw_got && s_q.w_got && commit_ok;
  assign rd_go = s_q.ar_got && commit_ok;
  // ****************************************
  // read mux
  // ****************************************
  always_comb begin
    rd_word = REG_RST;
    unique case (s_q.araddr)
      REG_POLE_PAIRS: rd_word = s_q.pole_pairs;
      REG_MAX_CURRENT: rd_word = s_q.max_cur;
      REG_RATED_CURRENT: rd_word = s_q.rated_cur;
      REG_PEAK_TIME: rd_word = s_q.peak_ms;
      REG_SUBMODE: rd_word = s_q.submode;
      REG_ENCODER_CFG: rd_word = s_q.enc_cfg;
      REG_MODE_OF_OP: rd_word = s_q.mode;
      REG_CONTROLWORD: rd_word = s_q.cw;
      REG_STATUSWORD: begin
        rd_word[SW_MODE_SPEC_BIT] = s_q.done;
        rd_word[SW_TARGET_REACHED_BIT_BIT] = s_q.done && s_q.idx_found;
        rd_word[SW_OPEN_BIT] = op_en;
      end
      REG_TARGET_VEL: rd_word = s_q.tvel;
      REG_SETUP_CFG: rd_word = s_q.setup_cfg;
      REG_PROG_STATUS: rd_word[0] = prog_run;
      REG_SETUP_STATUS: rd_word[3:0] = {s_q.coord_valid, s_q.setup_fail, s_q.setup_ok, busy};
      default: begin
        if (is_result(s_q.araddr)) begin
          rd_word[15:0] = s_q.res[s_q.araddr[4:2]];
        end
      end
    endcase
  end
  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    s_d = s_q;
    s_d.tstart = 1'b0;
    s_d.st_drive = 1'b0;
    s_d.st_tune = 1'b0;
    // bus handshakes
    if (s_axi_awvalid && s_q.awready) begin
      s_d.aw_got = 1'b1;
      s_d.awaddr = s_axi_awaddr;
      s_d.awready = 1'b0;
    end
    if (s_axi_wvalid && s_q.wready) begin
      s_d.w_got = 1'b1;
      s_d.wdata = s_axi_wdata;
      s_d.wstrb = s_axi_wstrb;
      s_d.wready = 1'b0;
    end
    if (s_axi_arvalid && s_q.arready) begin
      s_d.ar_got = 1'b1;
      s_d.araddr = s_axi_araddr;
      s_d.arready = 1'b0;
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
      s_d.awready = 1'b1;
      s_d.wready = 1'b1;
    end
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
      s_d.arready = 1'b1;
    end
    if ((s_q.aw_got && s_q.w_got) || s_q.ar_got) begin
      s_d.lat = commit_ok ? 3'h0 : s_q.lat + 3'h1;
    end
    if (wr_go) begin
      s_d.aw_got = 1'b0;
      s_d.w_got = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = RESP_OKAY;
      unique case (s_q.awaddr)
        REG_POLE_PAIRS: s_d.pole_pairs = strb_merge(s_q.pole_pairs, s_q.wdata, s_q.wstrb);
        REG_MAX_CURRENT: s_d.max_cur = strb_merge(s_q.max_cur, s_q.wdata, s_q.wstrb);
        REG_RATED_CURRENT: s_d.rated_cur = strb_merge(s_q.rated_cur, s_q.wdata, s_q.wstrb);
        REG_PEAK_TIME: s_d.peak_ms = strb_merge(s_q.peak_ms, s_q.wdata, s_q.wstrb);
        REG_SUBMODE: s_d.submode = strb_merge(s_q.submode, s_q.wdata, s_q.wstrb);
        REG_ENCODER_CFG: s_d.enc_cfg = strb_merge(s_q.enc_cfg, s_q.wdata, s_q.wstrb);
        REG_MODE_OF_OP: s_d.mode = strb_merge(s_q.mode, s_q.wdata, s_q.wstrb);
        REG_CONTROLWORD: s_d.cw = strb_merge(s_q.cw, s_q.wdata, s_q.wstrb);
        REG_TARGET_VEL: s_d.tvel = strb_merge(s_q.tvel, s_q.wdata, s_q.wstrb);
        REG_SETUP_CFG: s_d.setup_cfg = strb_merge(s_q.setup_cfg, s_q.wdata, s_q.wstrb);
        REG_STATUSWORD, REG_PROG_STATUS, REG_SETUP_STATUS: s_d.bresp = RESP_OKAY;
        default: s_d.bresp = is_result(s_q.awaddr) ? RESP_OKAY : RESP_SLVERR;
      endcase
    end
    if (rd_go) begin
      s_d.ar_got = 1'b0;
      s_d.rvalid = 1'b1;
      s_d.rdata = rd_word;
      s_d.rresp = (s_q.araddr <= REG_SETUP_STATUS && s_q.araddr[1:0] == 2'h0)
                  || is_result(s_q.araddr) ? RESP_OKAY : RESP_SLVERR;
    end
    // auto setup sequencer
    s_d.cw4_prev = s_q.cw[CW_START_BIT];
    s_d.idx_prev = idx_lvl;
    s_d.hall_prev = hall_lvl;
    if (s_q.phase == PH_IDLE) begin
      // no start while a user program owns the drive
      if (s_q.cw[CW_START_BIT] && !s_q.cw4_prev && op_en && !prog_run
          && s_q.mode[7:0] == MODE_AUTOSETUP) begin
        s_d.phase = PH_TYPE;
        s_d.tstart = 1'b1;
        s_d.done = 1'b0;
        s_d.setup_ok = 1'b0;
        s_d.setup_fail = 1'b0;
        s_d.idx_found = 1'b0;
        s_d.hall_cnt = '0;
      end
    end else if (limit_hit || !op_en) begin
      // limit switches keep guarding the axis during the test runs
      s_d.phase = PH_IDLE;
      s_d.setup_fail = 1'b1;
    end else if (s_q.phase == PH_STORE) begin
      s_d.phase = PH_IDLE;
      s_d.setup_ok = 1'b1;
      s_d.done = 1'b1;
      s_d.st_drive = 1'b1;
      s_d.st_tune = 1'b1;
      s_d.coord_valid = 1'b0;
    end else begin
      if ((s_q.phase == PH_ENC || s_q.phase == PH_ALIGN) && idx_lvl && !s_q.idx_prev) begin
        s_d.idx_found = 1'b1;
      end
      if (s_q.phase == PH_HALL && hall_lvl != s_q.hall_prev) begin
        s_d.hall_cnt = s_q.hall_cnt + 16'h0001;
      end
      if (tmr_done) begin
        // results land in their objects as each run ends
        s_d.res[3'(s_q.phase - PH_TYPE)] = (s_q.phase == PH_HALL) ? s_q.hall_cnt : meas_value;
        s_d.phase = next_phase(s_q.phase, s_q.setup_cfg);
        s_d.tstart = (s_d.phase != PH_STORE);
      end
    end
    // drive configuration decode
    s_d.cfg.bldc = s_q.submode[SM_BLDC_BIT];
    s_d.cfg.cur_reduce = s_q.submode[SM_CURRED_BIT] && !s_q.submode[SM_BLDC_BIT];
    s_d.cfg.brake_en = s_q.submode[SM_BRAKE_BIT];
    s_d.cfg.closed_loop = s_q.submode[SM_CLOSED_BIT] && s_q.setup_ok;
    s_d.cfg.enc_single_ended = s_q.enc_cfg[ENC_SE_BIT];
    s_d.cfg.pole_pairs = s_q.pole_pairs[7:0];
    s_d.cfg.peak_ma = s_q.max_cur[15:0];
    s_d.cfg.rated_ma = s_q.submode[SM_BLDC_BIT] ? s_q.rated_cur[15:0] : s_q.max_cur[15:0];
    s_d.cfg.peak_time_ms = s_q.submode[SM_BLDC_BIT] ? s_q.peak_ms[15:0] : 16'h0000;
    // a stop controlword clears operation enabled, so the motor drops
    s_d.motor_en = op_en && (busy || s_q.mode[7:0] == MODE_VELOCITY);
    s_d.vel = (op_en && s_q.mode[7:0] == MODE_VELOCITY) ? s_q.tvel : REG_RST;
    // registered copy of busy so the pin leaves a flop, same cycle as phase
    s_d.busy_o = (s_d.phase != PH_IDLE);
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
      s_q.awready <= 1'b1;
      s_q.wready <= 1'b1;
      s_q.arready <= 1'b1;
      s_q.coord_valid <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end
  assign s_axi_awready = s_q.awready;
  assign s_axi_wready = s_q.wready;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_arready = s_q.arready;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
  assign drive_cfg = s_q.cfg;
  assign motor_en = s_q.motor_en;
  assign setup_busy = s_q.busy_o;
  assign velocity_cmd = s_q.vel;
  assign store_drive = s_q.st_drive;
  assign store_tuning = s_q.st_tune;
  // ****************************************
  // checks
  // ****************************************
  chk_busy_done_low: assert property (@(posedge aclk) disable iff (!aresetn)
    busy |-> !s_q.done) else $error("completion bit set while setup runs");
  chk_store_sets_done: assert property (@(posedge aclk) disable iff (!aresetn)
    s_q.phase == PH_STORE && op_en && !limit_hit |=> s_q.done && !busy)
    else $error("setup end did not raise completion");
  chk_store_pulses: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(s_q.done) |-> s_q.st_drive && s_q.st_tune && s_q.setup_ok ##1 !s_q.st_drive)
    else $error("store pulses wrong around success");
  chk_closed_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    s_q.cfg.closed_loop |-> $past(s_q.setup_ok)) else $error("closed loop without setup");
  chk_bldc_decode: assert property (@(posedge aclk) disable iff (!aresetn)
    s_q.submode == SUBMODE_BLDC |=> s_q.cfg.bldc && !s_q.cfg.brake_en)
    else $error("bldc submode misdecoded");
  chk_step_decode: assert property (@(posedge aclk) disable iff (!aresetn)
    s_q.submode == SUBMODE_STEP_CR |=> !s_q.cfg.bldc && s_q.cfg.cur_reduce)
    else $error("stepper submode misdecoded");
  chk_brake_decode: assert property (@(posedge aclk) disable iff (!aresetn)
    s_q.submode == SUBMODE_STEP_BRAKE || s_q.submode == SUBMODE_BLDC_BRAKE
    |=> s_q.cfg.brake_en) else $error("brake control not enabled");
  chk_enc_decode: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_q.enc_cfg == ENC_SE_5V |=> s_q.cfg.enc_single_ended)
    and (s_q.enc_cfg == ENC_DIFF_5V |=> !s_q.cfg.enc_single_ended))
    else $error("encoder input type misdecoded");
  chk_current_sel: assert property (@(posedge aclk) disable iff (!aresetn)
    s_q.submode[SM_BLDC_BIT] |=> s_q.cfg.rated_ma == $past(s_q.rated_cur[15:0])
    && s_q.cfg.peak_ma == $past(s_q.max_cur[15:0]))
    else $error("bldc currents not from their objects");
  chk_limit_abort: assert property (@(posedge aclk) disable iff (!aresetn)
    busy && limit_hit |=> !busy && s_q.setup_fail) else $error("limit ignored in setup");
  chk_skip_encoder: assert property (@(posedge aclk) disable iff (!aresetn)
    s_q.phase == PH_FLUX && tmr_done && !limit_hit && op_en && !s_q.setup_cfg[CFG_INDEX_BIT]
    |=> s_q.phase != PH_ENC) else $error("encoder run without index");
  chk_vel_follow: assert property (@(posedge aclk) disable iff (!aresetn)
    op_en && s_q.mode[7:0] == MODE_VELOCITY |=> s_q.vel == $past(s_q.tvel) && s_q.motor_en)
    else $error("velocity not followed");
  chk_stop_word: assert property (@(posedge aclk) disable iff (!aresetn)
    s_q.cw == {16'h0000, CW_STOP} |=> !s_q.motor_en && s_q.vel == REG_RST)
    else $error("stop controlword left motor running");
endmodule
`default_nettype wire

//--- design/mcs_pkg.sv
package mcs_pkg;
  // ****************************************
  // bus and register map
  // ****************************************
  localparam int ADDR_W = 8;
  localparam logic [7:0] REG_POLE_PAIRS = 8'h00;
  localparam logic [7:0] REG_MAX_CURRENT = 8'h04;
  localparam logic [7:0] REG_RATED_CURRENT = 8'h08;
  localparam logic [7:0] REG_PEAK_TIME = 8'h0C;
  localparam logic [7:0] REG_SUBMODE = 8'h10;
  localparam logic [7:0] REG_ENCODER_CFG = 8'h14;
  localparam logic [7:0] REG_MODE_OF_OP = 8'h18;
  localparam logic [7:0] REG_CONTROLWORD = 8'h1C;
  localparam logic [7:0] REG_STATUSWORD = 8'h20;
  localparam logic [7:0] REG_TARGET_VEL = 8'h24;
  localparam logic [7:0] REG_SETUP_CFG = 8'h28;
  localparam logic [7:0] REG_PROG_STATUS = 8'h2C;
  localparam logic [7:0] REG_SETUP_STATUS = 8'h30;
  localparam logic [7:0] REG_RESULT_BASE = 8'h40;
  localparam int RES_N = 7;
  localparam logic [31:0] REG_RST = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ****************************************
  // field positions and values
  // ****************************************
  localparam int SM_CLOSED_BIT = 0;
  localparam int SM_BRAKE_BIT = 2;
  localparam int SM_CURRED_BIT = 3;
  localparam int SM_BLDC_BIT = 6;
  localparam logic [31:0] SUBMODE_STEP_CR = 32'h0000_0008;
  localparam logic [31:0] SUBMODE_BLDC = 32'h0000_0041;
  localparam logic [31:0] SUBMODE_STEP_BRAKE = 32'h0000_000C;
  localparam logic [31:0] SUBMODE_BLDC_BRAKE = 32'h0000_0044;
  localparam int ENC_SE_BIT = 1;
  localparam logic [31:0] ENC_DIFF_5V = 32'h0000_0000;
  localparam logic [31:0] ENC_SE_5V = 32'h0000_0002;
  localparam int CW_START_BIT = 4;
  localparam logic [3:0] CW_OP_ENABLE = 4'hF;
  localparam logic [15:0] CW_STOP = 16'h0006;
  localparam int SW_OPEN_BIT = 2;
  localparam int SW_TARGET_REACHED_BIT_BIT = 10;
  localparam int SW_MODE_SPEC_BIT = 12;
  localparam logic [7:0] MODE_AUTOSETUP = 8'hFE;
  localparam logic [7:0] MODE_VELOCITY = 8'h02;
  localparam int CFG_INDEX_BIT = 0;
  localparam int CFG_HALL_BIT = 1;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_NS = 10;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES_DEF = MS_NS / CLK_NS;
  localparam logic [7:0] PHASE_MS = 8'h0A;
  localparam logic [2:0] BUSY_LAT = 3'h4;
  // ****************************************
  // types
  // ****************************************
  typedef enum logic [3:0] {
    PH_IDLE, PH_TYPE, PH_RES, PH_IND, PH_FLUX, PH_ENC, PH_ALIGN, PH_HALL, PH_STORE
  } mcs_phase_t;
  typedef struct packed {
    logic bldc;
    logic closed_loop;
    logic brake_en;
    logic cur_reduce;
    logic enc_single_ended;
    logic [7:0] pole_pairs;
    logic [15:0] peak_ma;
    logic [15:0] rated_ma;
    logic [15:0] peak_time_ms;
  } mcs_drive_cfg_t;
endpackage

//--- design/mcs_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module mcs_pin_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] pin,
  output logic [W-1:0] level
);
  import mcs_pkg::*;
  typedef struct packed {
    logic [W-1:0] f1;
    logic [W-1:0] f2;
    logic [W-1:0] f3;
    logic [W-1:0] out;
  } mcs_sync_t;
  mcs_sync_t s_q, s_d;
  // a change counts only once the second and third stage agree
  always_comb begin
    s_d = s_q;
    s_d.f1 = pin;
    s_d.f2 = s_q.f1;
    s_d.f3 = s_q.f2;
    for (int i = 0; i < W; i++) begin
      if (s_q.f2[i] == s_q.f3[i]) begin
        s_d.out[i] = s_q.f3[i];
      end
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign level = s_q.out;
endmodule
`default_nettype wire

//--- design/mcs_ms_timer.sv
`timescale 1ns/1ps
`default_nettype none
module mcs_ms_timer #(
  parameter int MS_CYCLES = mcs_pkg::MS_CYCLES_DEF
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [7:0] len_ms,
  output logic done
);
  import mcs_pkg::*;
  typedef struct packed {
    logic [16:0] pre;
    logic [7:0] ms;
    logic run;
    logic done;
  } mcs_tmr_t;
  mcs_tmr_t s_q, s_d;
  localparam logic [16:0] PRE_LAST = 17'(MS_CYCLES - 1);
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    if (start) begin
      s_d.pre = '0;
      s_d.ms = len_ms;
      s_d.run = 1'b1;
    end else if (s_q.run) begin
      if (s_q.pre == PRE_LAST) begin
        s_d.pre = '0;
        s_d.ms = s_q.ms - 8'h01;
        if (s_q.ms <= 8'h01) begin
          s_d.run = 1'b0;
          s_d.done = 1'b1;
        end
      end else begin
        s_d.pre = s_q.pre + 17'h00001;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign done = s_q.done;
endmodule
`default_nettype wire

//--- bench/mcs_host.sv
`timescale 1ns/1ps
`default_nettype none
module mcs_host (
  input wire logic aclk,
  output logic [mcs_pkg::ADDR_W-1:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [mcs_pkg::ADDR_W-1:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  import mcs_pkg::*;
  // ****
  // fieldbus master side
  // ****
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
  end
  // no wait count assumed: replies lag while setup runs
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
endmodule
`default_nettype wire

//--- bench/motor_commissioning_autosetup_bench.sv
`timescale 1ns/1ps
`default_nettype none
module motor_commissioning_autosetup_bench;
  import mcs_pkg::*;
  logic aclk, aresetn, index_pin, motor_en, setup_busy, store_drive, store_tuning;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, velocity_cmd, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic limit_pos_pin, prog_run_pin, idx_run;
  logic [2:0] idx_div = 3'h0;
  mcs_drive_cfg_t drive_cfg;
  int n_mismatch = 0, comparisons = 0, n_store = 0;
  // short millisecond keeps the whole setup near six hundred cycles
  mcs_autosetup #(.MS_CYCLES(10)) u_mcs_autosetup (.*, .hall_pin(3'h0),
    .limit_neg_pin(1'b0), .meas_value(16'h1234));
  mcs_host m_host (.*);
  // ****
  // clock, checks, verdict
  // ****
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  always @(posedge aclk) if (store_drive === 1'b1 && store_tuning === 1'b1) n_store <= n_store + 1;
  // index pulse train, four cycles high so the pin filter keeps it
  always @(posedge aclk) begin
    idx_div <= idx_div + 3'h1;
    index_pin <= idx_run && idx_div[2];
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("mismatches=%0d comparisons=%0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic settle;
    repeat (2) @(posedge aclk);
    #1;
  endtask
  task automatic wait_busy(input logic lvl, input int lim);
    int k;
    k = 0;
    while (setup_busy !== lvl && k < lim) begin
      @(posedge aclk);
      k++;
    end
  endtask
  task automatic t_motor_data;
    logic [31:0] sm [4] = '{32'h08, 32'h41, 32'h0C, 32'h44};
    logic [2:0] ex [4] = '{3'b001, 3'b100, 3'b011, 3'b110};
    m_host.wr(REG_POLE_PAIRS, 32'd50, rsp);
    foreach (sm[i]) begin
      m_host.wr(REG_SUBMODE, sm[i], rsp);
      settle();
      check({drive_cfg.bldc, drive_cfg.brake_en, drive_cfg.cur_reduce}, ex[i]);
    end
    m_host.wr(REG_MAX_CURRENT, 32'd2000, rsp);
    m_host.wr(REG_RATED_CURRENT, 32'd1000, rsp);
    m_host.wr(REG_PEAK_TIME, 32'd100, rsp);
    settle();
    check({drive_cfg.peak_ma, drive_cfg.rated_ma}, {16'd2000, 16'd1000});
    check(drive_cfg.peak_time_ms, 32'd100);
    check(drive_cfg.pole_pairs, 32'd50);
    m_host.wr(REG_SUBMODE, 32'h08, rsp);
    m_host.wr(REG_ENCODER_CFG, 32'h02, rsp);
    settle();
    check(drive_cfg.rated_ma, 32'd2000);
    check(drive_cfg.enc_single_ended, 32'h1);
    m_host.wr(REG_ENCODER_CFG, 32'h00, rsp);
    settle();
    check(drive_cfg.enc_single_ended, 32'h0);
    m_host.wr(8'hFC, 32'h1, rsp);
    check(rsp, RESP_SLVERR);
    m_host.rd(8'hFC, d, rsp);
    check(rsp, RESP_SLVERR);
  endtask
  task automatic t_autosetup;
    prog_run_pin <= 1'b1;
    m_host.wr(REG_SUBMODE, 32'h41, rsp);
    m_host.wr(REG_SETUP_CFG, 32'h1, rsp);
    settle();
    check(drive_cfg.closed_loop, 32'h0);
    m_host.wr(REG_MODE_OF_OP, 32'hFE, rsp);
    m_host.wr(REG_CONTROLWORD, 32'h0F, rsp);
    m_host.wr(REG_CONTROLWORD, 32'h1F, rsp);
    wait_busy(1'b1, 20);
    check(setup_busy, 32'h0);
    prog_run_pin <= 1'b0;
    m_host.wr(REG_CONTROLWORD, 32'h0F, rsp);
    m_host.rd(REG_PROG_STATUS, d, rsp);
    check(d[0], 32'h0);
    m_host.wr(REG_CONTROLWORD, 32'h1F, rsp);
    wait_busy(1'b1, 20);
    check(setup_busy, 32'h1);
    idx_run <= 1'b1;
    m_host.rd(REG_STATUSWORD, d, rsp);
    check(d[12], 32'h0);
    wait_busy(1'b0, 3000);
    settle();
    m_host.rd(REG_STATUSWORD, d, rsp);
    check({d[12], d[10]}, 32'h3);
    check(n_store, 32'd1);
    check(drive_cfg.closed_loop, 32'h1);
    idx_run <= 1'b0;
  endtask
  task automatic t_velocity;
    m_host.wr(REG_MODE_OF_OP, 32'h02, rsp);
    m_host.wr(REG_TARGET_VEL, 32'd1000, rsp);
    m_host.wr(REG_CONTROLWORD, 32'h0F, rsp);
    settle();
    check(motor_en, 32'h1);
    check(velocity_cmd, 32'd1000);
    m_host.wr(REG_CONTROLWORD, 32'h06, rsp);
    settle();
    check(motor_en, 32'h0);
    check(velocity_cmd, 32'h0);
  endtask
  task automatic t_rerun;
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    m_host.rd(REG_SETUP_STATUS, d, rsp);
    check(d[3:0], 32'h8);
    m_host.wr(REG_SETUP_CFG, 32'h2, rsp);
    m_host.wr(REG_MODE_OF_OP, 32'hFE, rsp);
    m_host.wr(REG_CONTROLWORD, 32'h0F, rsp);
    m_host.wr(REG_CONTROLWORD, 32'h1F, rsp);
    wait_busy(1'b1, 20);
    wait_busy(1'b0, 3000);
    m_host.rd(REG_STATUSWORD, d, rsp);
    check({d[12], d[10]}, 32'h2);
    check(n_store, 32'd2);
    m_host.wr(REG_CONTROLWORD, 32'h0F, rsp);
    m_host.wr(REG_CONTROLWORD, 32'h1F, rsp);
    wait_busy(1'b1, 20);
    limit_pos_pin <= 1'b1;
    wait_busy(1'b0, 50);
    check(setup_busy, 32'h0);
    m_host.rd(REG_SETUP_STATUS, d, rsp);
    check(d[3:0], 32'h4);
    m_host.rd(REG_STATUSWORD, d, rsp);
    check(d[12], 32'h0);
    limit_pos_pin <= 1'b0;
  endtask
  initial begin
    #200000;
    n_mismatch++;
    complete_run();
  end
  initial begin
    aresetn = 1'b0;
    {limit_pos_pin, prog_run_pin, idx_run} = '0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    t_motor_data();
    t_autosetup();
    t_velocity();
    t_rerun();
    complete_run();
  end
endmodule
`default_nettype wire
